// ===== rtl/cmb_msg_buffer.sv
`timescale 1ns/100ps
module cmb_msg_buffer (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire cmb_pkg::cmb_rx_t     rxIn,
  input  wire cmb_pkg::cmb_tx_t     txIn,
  input  wire logic                 itTick,
  output logic [7:0]                rxFifoIrq,
  output logic [5:0]                comboRxIrq,
  output logic [1:0]                chTxIrq,
  output logic                      globalErrIrq,
  output logic [5:0]                comboTxPend,
  output logic [31:0]               txLinkReq,
  output logic [31:0]               txBufReq
);
  import cmb_pkg::*;

  typedef struct packed {
    logic                  hrdy;
    logic [31:0]           rdata;
    logic                  wrPend;
    logic [7:0]            wrAddr;
    logic                  dlcChk;
    logic [4:0]            rxBufCnt;
    logic [30:0]           rxBufNew;
    logic [2:0]            errEn;
    logic [2:0]            errFlag;
    logic [7:0]            rfEn;
    logic [7:0]            rfIe;
    logic [7:0]            rfMode;
    logic [7:0]            rfFlag;
    logic [7:0][2:0]       rfDepth;
    logic [7:0][2:0]       rfThr;
    logic [7:0][4:0]       rfCnt;
    logic [5:0]            cfEn;
    logic [5:0]            cfIe;
    logic [5:0]            cfTx;
    logic [5:0]            cfMode;
    logic [5:0]            cfFlag;
    logic [5:0]            cfTick;
    logic [5:0][2:0]       cfDepth;
    logic [5:0][2:0]       cfThr;
    logic [5:0][4:0]       cfCnt;
    logic [5:0][7:0]       cfIval;
    logic [5:0][7:0]       cfTimer;
    logic [5:0][3:0]       cfLink;
    logic [1:0][15:0]      txPend;
    logic [1:0][15:0]      txIe;
    logic [1:0][15:0]      txDone;
    logic [1:0][15:0]      linkReq;
    logic [1:0]            abortIe;
    logic [1:0]            abortFlag;
    logic [1:0]            histIe;
    logic [1:0]            histFlag;
    logic [1:0]            histAll;
    logic [1:0][15:0][7:0] histMem;
    logic [1:0][3:0]       histWr;
    logic [1:0][3:0]       histRd;
    logic [1:0][4:0]       histCnt;
    logic [7:0]            rfIrq;
    logic [5:0]            cfRxIrq;
    logic [5:0]            cfPend;
    logic [1:0]            txIrq;
    logic                  errIrq;
  } cmb_state_t;

  cmb_state_t q;
  cmb_state_t d;

  // Capacity of a FIFO is four messages per depth step.
  function automatic logic [4:0] fifo_cap(input logic [2:0] depth);
    fifo_cap = {depth, 2'b00};
  endfunction : fifo_cap

  // Fill level for threshold mode: capacity times (thr+1)/8, at least one.
  function automatic logic [4:0] fill_level(input logic [2:0] depth,
                                            input logic [2:0] thr);
    logic [5:0] p;
    p = {3'h0, depth} * {3'h0, thr} + {3'h0, depth};
    fill_level = (p[5:1] == 5'h00) ? 5'h01 : p[5:1];
  endfunction : fill_level

  // Register read multiplexer; unmapped offsets read as zero.
  function automatic logic [31:0] rd_word(input cmb_state_t s,
                                          input logic [7:0] a);
    logic [31:0] r;
    r = RST_WORD;
    if (a == ADDR_GCFG) begin
      r[G_DLCCHK] = s.dlcChk;
      r[G_RXBUF_LSB +: 5] = s.rxBufCnt;
      r[G_ERREN_LSB +: 3] = s.errEn;
      r[G_HALL_LSB +: 2] = s.histAll;
      r[G_HIE_LSB +: 2] = s.histIe;
    end
    if (a == ADDR_GERR) r[2:0] = s.errFlag;
    if (a == ADDR_RXBUF) r[30:0] = s.rxBufNew;
    for (int i = 0; i < NUM_RF; i++) begin
      if (a == 8'(ADDR_RFCC + 4 * i)) begin
        r[CC_EN] = s.rfEn[i];
        r[CC_IE] = s.rfIe[i];
        r[CC_DEPTH_LSB +: 3] = s.rfDepth[i];
        r[CC_IMODE] = s.rfMode[i];
        r[CC_THR_LSB +: 3] = s.rfThr[i];
        r[CC_CNT_LSB +: 5] = s.rfCnt[i];
        r[CC_FULL] = (s.rfCnt[i] == fifo_cap(s.rfDepth[i]));
        r[CC_EMPTY] = (s.rfCnt[i] == 5'h00);
        r[CC_FLAG] = s.rfFlag[i];
      end
    end
    for (int k = 0; k < NUM_CF; k++) begin
      if (a == 8'(ADDR_CFCC + 4 * k)) begin
        r[CC_EN] = s.cfEn[k];
        r[CC_IE] = s.cfIe[k];
        r[CC_TXMODE] = s.cfTx[k];
        r[CC_DEPTH_LSB +: 3] = s.cfDepth[k];
        r[CC_IMODE] = s.cfMode[k];
        r[CC_THR_LSB +: 3] = s.cfThr[k];
        r[CC_CNT_LSB +: 5] = s.cfCnt[k];
        r[CC_FULL] = (s.cfCnt[k] == fifo_cap(s.cfDepth[k]));
        r[CC_EMPTY] = (s.cfCnt[k] == 5'h00);
        r[CC_FLAG] = s.cfFlag[k];
      end
      if (a == 8'(ADDR_CFTIM + 4 * k)) begin
        r[TM_IVAL_LSB +: 8] = s.cfIval[k];
        r[TM_TICK] = s.cfTick[k];
        r[TM_LINK_LSB +: 4] = s.cfLink[k];
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (a == 8'(ADDR_TXREQ + 4 * c)) r[15:0] = s.txPend[c];
      if (a == 8'(ADDR_TXIE + 4 * c)) begin
        r[15:0] = s.txIe[c];
        r[TX_ABORT] = s.abortIe[c];
      end
      if (a == 8'(ADDR_TXSTS + 4 * c)) begin
        r[15:0] = s.txDone[c];
        r[TX_ABORT] = s.abortFlag[c];
        r[TX_HIST] = s.histFlag[c];
      end
      if (a == 8'(ADDR_HIST + 4 * c)) begin
        r[7:0] = s.histMem[c][s.histRd[c]];
        r[HS_CNT_LSB +: 5] = s.histCnt[c];
      end
    end
    rd_word = r;
  endfunction : rd_word

  // Next-state logic: bus access first, then hardware events so hardware events win.
  always_comb begin
    logic       busAct;
    logic [1:0] histPush;
    logic [1:0][7:0] histRec;
    int         kk;
    logic [3:0] bb;
    busAct = hsel & htrans[1] & hready;
    histPush = 2'b00;
    histRec = '0;
    kk = 0;
    bb = 4'h0;
    d = q;
    d.hrdy = 1'b1;
    d.wrPend = busAct & hwrite;
    d.wrAddr = haddr[7:0];
    d.rdata = (busAct & ~hwrite) ? rd_word(q, haddr[7:0]) : RST_WORD;

    // Write data phase.
    if (q.wrPend) begin
      if (q.wrAddr == ADDR_GCFG) begin
        d.dlcChk = hwdata[G_DLCCHK];
        d.rxBufCnt = hwdata[G_RXBUF_LSB +: 5];
        d.errEn = hwdata[G_ERREN_LSB +: 3];
        d.histAll = hwdata[G_HALL_LSB +: 2];
        d.histIe = hwdata[G_HIE_LSB +: 2];
      end
      if (q.wrAddr == ADDR_GERR) d.errFlag = q.errFlag & ~hwdata[2:0];
      if (q.wrAddr == ADDR_RXBUF) d.rxBufNew = q.rxBufNew & ~hwdata[30:0];
      for (int i = 0; i < NUM_RF; i++) begin
        if (q.wrAddr == 8'(ADDR_RFCC + 4 * i)) begin
          d.rfEn[i] = hwdata[CC_EN];
          d.rfIe[i] = hwdata[CC_IE];
          d.rfDepth[i] = hwdata[CC_DEPTH_LSB +: 3];
          d.rfMode[i] = hwdata[CC_IMODE];
          d.rfThr[i] = hwdata[CC_THR_LSB +: 3];
          if (hwdata[CC_FLAG]) d.rfFlag[i] = 1'b0;
          if (hwdata[CC_CMD] && q.rfCnt[i] != 5'h00) begin
            d.rfCnt[i] = q.rfCnt[i] - 5'h01;
          end
          if (!hwdata[CC_EN]) d.rfCnt[i] = 5'h00;
        end
      end
      for (int k = 0; k < NUM_CF; k++) begin
        if (q.wrAddr == 8'(ADDR_CFCC + 4 * k)) begin
          d.cfEn[k] = hwdata[CC_EN];
          d.cfIe[k] = hwdata[CC_IE];
          d.cfTx[k] = hwdata[CC_TXMODE];
          d.cfDepth[k] = hwdata[CC_DEPTH_LSB +: 3];
          d.cfMode[k] = hwdata[CC_IMODE];
          d.cfThr[k] = hwdata[CC_THR_LSB +: 3];
          if (hwdata[CC_FLAG]) d.cfFlag[k] = 1'b0;
          // Command bit pops in receive mode and pushes in transmit mode.
          if (hwdata[CC_CMD] && !q.cfTx[k] && q.cfCnt[k] != 5'h00) begin
            d.cfCnt[k] = q.cfCnt[k] - 5'h01;
          end
          if (hwdata[CC_CMD] && q.cfTx[k] &&
              q.cfCnt[k] != fifo_cap(q.cfDepth[k])) begin
            d.cfCnt[k] = q.cfCnt[k] + 5'h01;
          end
          if (!hwdata[CC_EN] || hwdata[CC_TXMODE] != q.cfTx[k]) begin
            d.cfCnt[k] = 5'h00;
          end
        end
        if (q.wrAddr == 8'(ADDR_CFTIM + 4 * k)) begin
          d.cfIval[k] = hwdata[TM_IVAL_LSB +: 8];
          d.cfTick[k] = hwdata[TM_TICK];
          d.cfLink[k] = hwdata[TM_LINK_LSB +: 4];
        end
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (q.wrAddr == 8'(ADDR_TXREQ + 4 * c)) begin
          d.txPend[c] = q.txPend[c] | hwdata[15:0];
        end
        if (q.wrAddr == 8'(ADDR_TXIE + 4 * c)) begin
          d.txIe[c] = hwdata[15:0];
          d.abortIe[c] = hwdata[TX_ABORT];
        end
        if (q.wrAddr == 8'(ADDR_TXSTS + 4 * c)) begin
          d.txDone[c] = q.txDone[c] & ~hwdata[15:0];
          if (hwdata[TX_ABORT]) d.abortFlag[c] = 1'b0;
          if (hwdata[TX_HIST]) d.histFlag[c] = 1'b0;
        end
        if (q.wrAddr == 8'(ADDR_HIST + 4 * c) && q.histCnt[c] != 5'h00) begin
          d.histRd[c] = q.histRd[c] + 4'h1;
          d.histCnt[c] = q.histCnt[c] - 5'h01;
        end
      end
    end

    // Interval timers count down only in transmit mode.
    for (int k = 0; k < NUM_CF; k++) begin
      if (!d.cfEn[k] || !d.cfTx[k]) begin
        d.cfTimer[k] = 8'h00;
      end else if (q.cfTimer[k] != 8'h00 && (!q.cfTick[k] || itTick)) begin
        d.cfTimer[k] = q.cfTimer[k] - 8'h01;
      end
    end

    // Received message storage.
    if (rxIn.valid) begin
      if (q.dlcChk && rxIn.dlc < rxIn.ruleDlc) begin
        d.errFlag[ERR_DLC] = 1'b1;
      end else if (rxIn.dest == DEST_RXBUF) begin
        if (rxIn.idx < q.rxBufCnt) begin
          d.rxBufNew[rxIn.idx] = 1'b1;
        end
      end else if (rxIn.dest == DEST_RXFIFO) begin
        kk = int'(rxIn.idx[2:0]);
        if (d.rfEn[kk] && rxIn.idx < 5'(NUM_RF)) begin
          if (d.rfCnt[kk] == fifo_cap(d.rfDepth[kk])) begin
            d.errFlag[ERR_LOST] = 1'b1;
          end else begin
            d.rfCnt[kk] = d.rfCnt[kk] + 5'h01;
            if (d.rfIe[kk] && (d.rfMode[kk] ||
                d.rfCnt[kk] == fill_level(d.rfDepth[kk], d.rfThr[kk]))) begin
              d.rfFlag[kk] = 1'b1;
            end
          end
        end
      end else if (rxIn.dest == DEST_COMBO && rxIn.idx < 5'(NUM_CF)) begin
        kk = int'(rxIn.idx[2:0]);
        if (d.cfEn[kk] && !d.cfTx[kk]) begin
          if (d.cfCnt[kk] == fifo_cap(d.cfDepth[kk])) begin
            d.errFlag[ERR_LOST] = 1'b1;
          end else begin
            d.cfCnt[kk] = d.cfCnt[kk] + 5'h01;
            if (d.cfIe[kk] && (d.cfMode[kk] ||
                d.cfCnt[kk] == fill_level(d.cfDepth[kk], d.cfThr[kk]))) begin
              d.cfFlag[kk] = 1'b1;
            end
          end
        end
      end
    end

    // Transmit completion and abort reports.
    if (txIn.valid) begin
      bb = txIn.idx;
      if (txIn.fromFifo) begin
        kk = (txIn.ch ? CF_PER_CH : 0) + int'(txIn.idx[1:0]);
        if (txIn.idx < 4'(CF_PER_CH) && d.cfEn[kk] && d.cfTx[kk] &&
            d.cfCnt[kk] != 5'h00) begin
          d.cfCnt[kk] = d.cfCnt[kk] - 5'h01;
          d.cfTimer[kk] = q.cfIval[kk];
          if (d.cfIe[kk] && (d.cfMode[kk] || d.cfCnt[kk] == 5'h00)) begin
            d.cfFlag[kk] = 1'b1;
          end
          histPush[txIn.ch] = txIn.record;
          histRec[txIn.ch] = {1'b1, 3'h0, txIn.idx};
        end
      end else if (txIn.abort) begin
        d.txPend[txIn.ch][bb] = 1'b0;
        d.abortFlag[txIn.ch] = 1'b1;
      end else begin
        d.txPend[txIn.ch][bb] = 1'b0;
        d.txDone[txIn.ch][bb] = 1'b1;
        histPush[txIn.ch] = txIn.record & q.histAll[txIn.ch];
        histRec[txIn.ch] = {1'b0, 3'h0, txIn.idx};
      end
    end

    // History buffers; a record arriving when full is dropped.
    for (int c = 0; c < NUM_CH; c++) begin
      if (histPush[c]) begin
        if (d.histCnt[c] == 5'(HIST_DEPTH)) begin
          d.errFlag[ERR_HOVF] = 1'b1;
        end else begin
          d.histMem[c][q.histWr[c]] = histRec[c];
          d.histWr[c] = q.histWr[c] + 4'h1;
          d.histCnt[c] = d.histCnt[c] + 5'h01;
          d.histFlag[c] = 1'b1;
        end
      end
    end

    // Registered request outputs.
    d.linkReq = '0;
    for (int k = 0; k < NUM_CF; k++) begin
      d.cfPend[k] = q.cfEn[k] & q.cfTx[k] & (q.cfCnt[k] != 5'h00) &
                    (q.cfTimer[k] == 8'h00);
      if (d.cfPend[k]) begin
        d.linkReq[k / CF_PER_CH][q.cfLink[k]] = 1'b1;
      end
    end
    d.rfIrq = q.rfFlag;
    d.cfRxIrq = q.cfFlag & ~q.cfTx;
    for (int c = 0; c < NUM_CH; c++) begin
      d.txIrq[c] = (|(q.txDone[c] & q.txIe[c])) |
                   (q.abortFlag[c] & q.abortIe[c]) |
                   (|(q.cfFlag[c * CF_PER_CH +: CF_PER_CH] &
                      q.cfTx[c * CF_PER_CH +: CF_PER_CH])) |
                   (q.histFlag[c] & q.histIe[c]);
    end
    d.errIrq = |(q.errFlag & q.errEn);
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.hrdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs other than hresp come straight from the state register.
  assign hreadyout    = q.hrdy;
  assign hresp        = HRESP_OKAY;
  assign hrdata       = q.rdata;
  assign rxFifoIrq    = q.rfIrq;
  assign comboRxIrq   = q.cfRxIrq;
  assign chTxIrq      = q.txIrq;
  assign globalErrIrq = q.errIrq;
  assign comboTxPend  = q.cfPend;
  assign txLinkReq    = q.linkReq;
  assign txBufReq     = q.txPend;

  AST_RXBUF_ZERO: assert property (@(posedge mclk) disable iff (rst)
    rxIn.valid && rxIn.dest == DEST_RXBUF && q.rxBufCnt == 5'h00 &&
    !q.wrPend |=> $stable(q.rxBufNew))
    else $error("Receive buffer stored while count is zero.");
  AST_RXBUF_NOIRQ: assert property (@(posedge mclk) disable iff (rst)
    rxIn.valid && rxIn.dest == DEST_RXBUF && !q.wrPend && !txIn.valid
    |=> $stable(q.rfFlag) && $stable(q.cfFlag))
    else $error("Receive buffer message raised an interrupt flag.");
  AST_RF_EVERY: assert property (@(posedge mclk) disable iff (rst)
    rxIn.valid && rxIn.dest == DEST_RXFIFO && rxIn.idx == 5'h00 &&
    !q.dlcChk && !q.wrPend && q.rfEn[0] && q.rfIe[0] && q.rfMode[0] &&
    q.rfCnt[0] != fifo_cap(q.rfDepth[0]) |-> ##2 rxFifoIrq[0])
    else $error("Receive FIFO did not request per message.");
  AST_LOST: assert property (@(posedge mclk) disable iff (rst)
    rxIn.valid && rxIn.dest == DEST_RXFIFO && rxIn.idx < 5'(NUM_RF) &&
    !q.dlcChk && !q.wrPend && q.rfEn[rxIn.idx[2:0]] &&
    q.rfCnt[rxIn.idx[2:0]] == fifo_cap(q.rfDepth[rxIn.idx[2:0]])
    |=> q.errFlag[ERR_LOST] && $stable(q.rfCnt))
    else $error("Message loss not flagged or full FIFO changed.");
  AST_HOVF: assert property (@(posedge mclk) disable iff (rst)
    q.histCnt[0] == 5'(HIST_DEPTH) && !q.wrPend && txIn.valid &&
    !txIn.ch && !txIn.fromFifo && !txIn.abort && txIn.record &&
    q.histAll[0] |=> q.errFlag[ERR_HOVF] && q.histCnt[0] == 5'(HIST_DEPTH))
    else $error("History overflow not flagged.");
  AST_GERR_MASK: assert property (@(posedge mclk) disable iff (rst)
    globalErrIrq |-> $past(|(q.errFlag & q.errEn)))
    else $error("Global error request without an enabled source.");
  AST_STICKY: assert property (@(posedge mclk) disable iff (rst)
    q.errFlag[ERR_LOST] && !(q.wrPend && q.wrAddr == ADDR_GERR)
    |=> q.errFlag[ERR_LOST])
    else $error("Message loss flag dropped without a clear.");
  AST_DISABLE: assert property (@(posedge mclk) disable iff (rst)
    q.wrPend && q.wrAddr == ADDR_RFCC && !hwdata[CC_EN]
    |=> q.rfCnt[0] == 5'h00 ##1 q.rfCnt[0] == 5'h00)
    else $error("Disabled receive FIFO not empty.");
  AST_TIMER_RX: assert property (@(posedge mclk) disable iff (rst)
    !q.cfTx[0] && !q.wrPend |=> q.cfTimer[0] == 8'h00)
    else $error("Interval timer running outside transmit mode.");
  AST_LINK: assert property (@(posedge mclk) disable iff (rst)
    |txLinkReq |-> $past(|(q.cfEn & q.cfTx)))
    else $error("Link request from a FIFO not in transmit mode.");

endmodule : cmb_msg_buffer

// ===== rtl/cmb_pkg.sv
package cmb_pkg;

  // Sizes of the buffer structure.
  localparam int NUM_CH     = 2;
  localparam int NUM_RF     = 8;
  localparam int NUM_CF     = 6;
  localparam int CF_PER_CH  = 3;
  localparam int NUM_TXB    = 16;
  localparam int HIST_DEPTH = 16;
  localparam int MAX_RXBUF  = 31;

  // Destinations of a received message.
  localparam logic [1:0] DEST_RXBUF  = 2'h0;
  localparam logic [1:0] DEST_RXFIFO = 2'h1;
  localparam logic [1:0] DEST_COMBO  = 2'h2;

  // Register byte offsets (low address byte).
  localparam logic [7:0] ADDR_GCFG  = 8'h00;
  localparam logic [7:0] ADDR_GERR  = 8'h04;
  localparam logic [7:0] ADDR_RXBUF = 8'h08;
  localparam logic [7:0] ADDR_RFCC  = 8'h10;
  localparam logic [7:0] ADDR_CFCC  = 8'h30;
  localparam logic [7:0] ADDR_CFTIM = 8'h50;
  localparam logic [7:0] ADDR_TXREQ = 8'h70;
  localparam logic [7:0] ADDR_TXIE  = 8'h78;
  localparam logic [7:0] ADDR_TXSTS = 8'h80;
  localparam logic [7:0] ADDR_HIST  = 8'h88;

  // Global configuration fields.
  localparam int G_DLCCHK    = 0;
  localparam int G_RXBUF_LSB = 8;
  localparam int G_ERREN_LSB = 16;
  localparam int G_HALL_LSB  = 24;
  localparam int G_HIE_LSB   = 26;

  // Global error flag positions.
  localparam int ERR_DLC  = 0;
  localparam int ERR_LOST = 1;
  localparam int ERR_HOVF = 2;

  // FIFO configuration/control fields.
  localparam int CC_EN        = 0;
  localparam int CC_IE        = 1;
  localparam int CC_TXMODE    = 2;
  localparam int CC_DEPTH_LSB = 8;
  localparam int CC_IMODE     = 12;
  localparam int CC_THR_LSB   = 13;
  localparam int CC_CNT_LSB   = 16;
  localparam int CC_FULL      = 21;
  localparam int CC_EMPTY     = 22;
  localparam int CC_FLAG      = 23;
  localparam int CC_CMD       = 31;

  // Interval timer and link fields.
  localparam int TM_IVAL_LSB = 0;
  localparam int TM_TICK     = 8;
  localparam int TM_LINK_LSB = 12;

  // Transmit status and enable fields.
  localparam int TX_ABORT = 16;
  localparam int TX_HIST  = 17;
  localparam int HS_CNT_LSB = 8;

  localparam logic       HRESP_OKAY = 1'b0;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;

  // Message that passed acceptance filtering.
  typedef struct packed {
    logic       valid;
    logic [1:0] dest;
    logic [4:0] idx;
    logic [3:0] dlc;
    logic [3:0] ruleDlc;
  } cmb_rx_t;

  // Completion or abort report from the transmit engine.
  typedef struct packed {
    logic       valid;
    logic       ch;
    logic       fromFifo;
    logic       abort;
    logic [3:0] idx;
    logic       record;
  } cmb_tx_t;

endpackage : cmb_pkg

// ===== testbench/cmb_can_node.sv
`timescale 1ns/100ps
// Other nodes on the bus: filtered frames in, send reports back.
module cmb_can_node
  import cmb_pkg::*;
(
  input  wire logic       mclk,
  output cmb_pkg::cmb_rx_t rxIn,
  output cmb_pkg::cmb_tx_t txIn,
  output logic            itTick
);
  // Idle values on rxIn and txIn hold until the first event is sent.
  initial begin
    rxIn = '0;
    txIn = '0;
    itTick = 1'b0;
  end
  // The timer tick source runs free on every other cycle.
  always @(posedge mclk) itTick <= ~itTick;
  // One received frame, a single-cycle pulse after a rising edge.
  task rx(input logic [1:0] d, input logic [4:0] i, input logic [3:0] l,
          input logic [3:0] r);
    @(posedge mclk);
    rxIn <= {1'b1, d, i, l, r};
    @(posedge mclk);
    rxIn <= '0;
  endtask : rx
  // One send report from the transmit side, also a single-cycle pulse.
  task tx(input logic c, input logic f, input logic a, input logic [3:0] i,
          input logic r);
    @(posedge mclk);
    txIn <= {1'b1, c, f, a, i, r};
    @(posedge mclk);
    txIn <= '0;
  endtask : tx
endmodule : cmb_can_node

// ===== testbench/cmb_msg_buffer_tb.sv
`timescale 1ns/100ps
`define CHK(n,e,g) begin comparisons++; if ((g) !== (e)) begin \
  mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end end
module cmb_msg_buffer_tb;
  import cmb_pkg::*;
  logic        mclk, rst, hsel, hwrite, hready, hreadyout, hresp, itTick;
  logic        globalErrIrq;
  logic [31:0] haddr, hwdata, hrdata, rdv, txLinkReq, txBufReq;
  logic [1:0]  htrans, chTxIrq;
  logic [2:0]  hsize;
  logic [7:0]  rxFifoIrq;
  logic [5:0]  comboRxIrq, comboTxPend;
  cmb_rx_t     rxIn;
  cmb_tx_t     txIn;
  int          mismatches, comparisons, cycles;
  assign hready = hreadyout;
  cmb_can_node i_cmb_can_node (.mclk(mclk), .rxIn(rxIn), .txIn(txIn),
    .itTick(itTick));
  cmb_msg_buffer i_cmb_msg_buffer (.mclk(mclk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rxIn(rxIn), .txIn(txIn),
    .itTick(itTick), .rxFifoIrq(rxFifoIrq), .comboRxIrq(comboRxIrq),
    .chTxIrq(chTxIrq), .globalErrIrq(globalErrIrq),
    .comboTxPend(comboTxPend), .txLinkReq(txLinkReq), .txBufReq(txBufReq));
  // Clock of 4 ns period.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // One single AHB transfer; read data is taken at the data phase edge.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'h0; hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rdv = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task chk(input string n, input logic [7:0] a, input logic [31:0] m,
           input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, rdv & m)
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt
  task t_rxbuf();
    i_cmb_can_node.rx(DEST_RXBUF, 5'h0, 4'h8, 4'h0);
    chk("rxbuf none", ADDR_RXBUF, 32'hffff_ffff, 32'h0);
    wr(ADDR_GCFG, 32'h0000_0200);
    i_cmb_can_node.rx(DEST_RXBUF, 5'h1, 4'h8, 4'h0);
    i_cmb_can_node.rx(DEST_RXBUF, 5'h2, 4'h8, 4'h0);
    wt(2);
    chk("rxbuf flags", ADDR_RXBUF, 32'hffff_ffff, 32'h2);
    `CHK("no irq", 17'h0, {rxFifoIrq, comboRxIrq, chTxIrq, globalErrIrq})
    $display("test rxbuf done");
  endtask : t_rxbuf
  task t_rxfifo();
    wr(ADDR_GCFG, 32'h0002_0000);
    wr(ADDR_RFCC + 8'h1c, 32'h0000_e103);
    repeat (3) i_cmb_can_node.rx(DEST_RXFIFO, 5'h7, 4'h8, 4'h0);
    wt(2);
    `CHK("rf below", 8'h00, rxFifoIrq)
    i_cmb_can_node.rx(DEST_RXFIFO, 5'h7, 4'h8, 4'h0);
    wt(2);
    `CHK("rf level", 8'h80, rxFifoIrq)
    i_cmb_can_node.rx(DEST_RXFIFO, 5'h7, 4'h8, 4'h0);
    wt(2);
    `CHK("lost irq", 1'b1, globalErrIrq)
    chk("rf state", ADDR_RFCC + 8'h1c, 32'h00ff_0000, 32'h00a4_0000);
    chk("lost flag", ADDR_GERR, 32'h7, 32'h2);
    wr(ADDR_GERR, 32'h2);
    chk("lost clr", ADDR_GERR, 32'h7, 32'h0);
    wr(ADDR_RFCC + 8'h1c, 32'h0);
    chk("rf empty", ADDR_RFCC + 8'h1c, 32'h007f_0000, 32'h0060_0000);
    wr(ADDR_RFCC, 32'h0000_1103);
    i_cmb_can_node.rx(DEST_RXFIFO, 5'h0, 4'h8, 4'h0);
    wt(2);
    `CHK("rf every", 1'b1, rxFifoIrq[0])
    wr(ADDR_RFCC, 32'h0);
    chk("rf0 empty", ADDR_RFCC, 32'h001f_0000, 32'h0);
    $display("test rxfifo done");
  endtask : t_rxfifo
  task t_dlc();
    wr(ADDR_GCFG, 32'h0000_0001);
    wr(ADDR_RFCC + 8'h04, 32'h0000_0103);
    i_cmb_can_node.rx(DEST_RXFIFO, 5'h1, 4'h2, 4'h5);
    wt(2);
    `CHK("dlc masked", 1'b0, globalErrIrq)
    chk("dlc flag", ADDR_GERR, 32'h7, 32'h1);
    chk("dlc drop", ADDR_RFCC + 8'h04, 32'h001f_0000, 32'h0);
    i_cmb_can_node.rx(DEST_RXFIFO, 5'h1, 4'h5, 4'h5);
    chk("dlc pass", ADDR_RFCC + 8'h04, 32'h001f_0000, 32'h0001_0000);
    wr(ADDR_GCFG, 32'h0001_0001);
    wt(2);
    `CHK("dlc irq", 1'b1, globalErrIrq)
    wr(ADDR_GERR, 32'h7);
    $display("test dlc done");
  endtask : t_dlc
  task t_combo();
    wr(ADDR_CFCC + 8'h14, 32'h0000_1103);
    i_cmb_can_node.rx(DEST_COMBO, 5'h5, 4'h8, 4'h0);
    wt(2);
    `CHK("cf rx irq", 6'h20, comboRxIrq)
    wr(ADDR_CFTIM + 8'h14, 32'h0000_3000);
    wr(ADDR_CFCC + 8'h14, 32'h0080_0107);
    wr(ADDR_CFCC + 8'h14, 32'h8000_0107);
    i_cmb_can_node.rx(DEST_COMBO, 5'h5, 4'h8, 4'h0);
    wt(2);
    `CHK("cf pend", 6'h20, comboTxPend)
    `CHK("cf link", 32'h0008_0000, txLinkReq)
    `CHK("cf no rx irq", 6'h00, comboRxIrq)
    chk("cf count", ADDR_CFCC + 8'h14, 32'h001f_0000, 32'h0001_0000);
    `CHK("cf tx idle", 1'b0, chTxIrq[1])
    i_cmb_can_node.tx(1'b1, 1'b1, 1'b0, 4'h2, 1'b0);
    wt(2);
    `CHK("cf empty irq", 1'b1, chTxIrq[1])
    wr(ADDR_CFCC + 8'h14, 32'h0080_0000);
    $display("test combo done");
  endtask : t_combo
  task t_hist();
    wr(ADDR_GCFG, 32'h0400_0000);
    i_cmb_can_node.tx(1'b0, 1'b0, 1'b0, 4'hf, 1'b1);
    chk("hist src", ADDR_HIST, 32'h1f00, 32'h0);
    wr(ADDR_GCFG, 32'h0504_0000);
    wr(ADDR_TXSTS, 32'h0003_ffff);
    wr(ADDR_TXIE, 32'h0000_8000);
    wr(ADDR_TXREQ, 32'h0000_8000);
    wt(2);
    `CHK("tx req", 32'h0000_8000, txBufReq)
    `CHK("tx idle", 1'b0, chTxIrq[0])
    i_cmb_can_node.tx(1'b0, 1'b0, 1'b0, 4'hf, 1'b1);
    wt(2);
    `CHK("tx done req", 32'h0, txBufReq)
    `CHK("tx irq", 1'b1, chTxIrq[0])
    chk("tx flag", ADDR_TXSTS, 32'h0000_8000, 32'h0000_8000);
    chk("hist one", ADDR_HIST, 32'h1fff, 32'h010f);
    i_cmb_can_node.tx(1'b0, 1'b0, 1'b0, 4'h1, 1'b0);
    chk("hist skip", ADDR_HIST, 32'h1f00, 32'h0100);
    repeat (16) i_cmb_can_node.tx(1'b0, 1'b0, 1'b0, 4'h1, 1'b1);
    chk("hist full", ADDR_HIST, 32'h1fff, 32'h100f);
    chk("hovf flag", ADDR_GERR, 32'h7, 32'h4);
    wt(2);
    `CHK("hovf irq", 1'b1, globalErrIrq)
    wr(ADDR_TXSTS, 32'h0003_ffff);
    wr(ADDR_TXIE, 32'h0001_0000);
    wr(ADDR_TXREQ, 32'h0000_0010);
    wt(2);
    `CHK("abort idle", 1'b0, chTxIrq[0])
    i_cmb_can_node.tx(1'b0, 1'b0, 1'b1, 4'h4, 1'b1);
    wt(2);
    `CHK("abort req", 32'h0, txBufReq)
    `CHK("abort irq", 1'b1, chTxIrq[0])
    wr(ADDR_HIST, 32'h0);
    chk("hist pop", ADDR_HIST, 32'h1fff, 32'h0f01);
    $display("test hist done");
  endtask : t_hist
  // Reset for ten cycles, then the scenarios in turn.
  initial begin
    rst = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    mismatches = 0; comparisons = 0; cycles = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_rxbuf();
    t_rxfifo();
    t_dlc();
    t_combo();
    t_hist();
    close_out();
  end
endmodule : cmb_msg_buffer_tb
